// file: hdl/mrp_port.sv
// mac side of an mii/rmii ethernet port toward an external phy
`include "mrp_regs.svh"
`timescale 1ns/1ps
module mrp_port #(
  parameter int DIV_W = 5
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic rmii_mode_i,
  input wire logic dce_mode_i,
  input wire logic speed_100_i,
  input wire logic full_duplex_i,
  input wire logic ref_clk_i,
  input wire logic tx_clk_i,
  output logic tx_clk_o,
  output logic tx_clk_oe_o,
  input wire logic rx_clk_i,
  output logic rx_clk_o,
  output logic rx_clk_oe_o,
  output logic divided_ref_clock_out_o,
  output logic tx_en_o,
  output logic [3:0] txd_o,
  input wire logic [3:0] rxd_i,
  input wire logic rx_dv_i,
  input wire logic receive_carrier_sense_i,
  input wire logic rx_err_i,
  input wire logic collision_detect_in_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  output logic tx_col_o,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic rx_end_o,
  output logic rx_err_o
);
  logic ref_q, txc_q, rxc_q;
  logic ref_rise, txc_rise, rxc_rise;
  logic gen_clk, gen_rise, dec_rise, refo_rise;
  logic mii_dce;
  logic tx_tick, rx_tick, rx_line_valid;
  logic [DIV_W-1:0] gen_half;
  mrp_pkg::mrp_tx_state_e tx_state, next_tx_state;
  logic [7:0] tx_sh, next_tx_sh;
  logic [1:0] tx_cnt, next_tx_cnt;
  logic tx_last_q, next_tx_last_q;
  logic next_tx_en, next_tx_ready, next_tx_col;
  logic [3:0] next_txd;
  logic [7:0] rx_sh, next_rx_sh;
  logic [1:0] rx_cnt, next_rx_cnt;
  logic rx_in_frame, next_rx_in_frame, rx_err_acc, next_rx_err_acc;
  logic [7:0] next_rx_byte;
  logic next_rx_valid, next_rx_end, next_rx_err;

  function automatic logic [3:0] first_unit(input logic [7:0] b, input logic rmii);
    first_unit = rmii ? {2'h0, b[1:0]} : b[3:0];
  endfunction

  function automatic logic [7:0] drop_unit(input logic [7:0] b, input logic rmii);
    drop_unit = rmii ? (b >> `MRP_RMII_SHIFT) : (b >> `MRP_MII_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clock edges and tick selection
  // pins are synchronous to sys_clk_i, so one stage is enough for edges
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref_q <= 1'b0;
      txc_q <= 1'b0;
      rxc_q <= 1'b0;
    end
    else
    begin
      ref_q <= ref_clk_i;
      txc_q <= tx_clk_i;
      rxc_q <= rx_clk_i;
    end
  end

  // the reference edge is only consumed in rmii or dce, so mii dte may tie it low
  assign ref_rise = ref_clk_i & ~ref_q & (rmii_mode_i | dce_mode_i);
  assign txc_rise = tx_clk_i & ~txc_q;
  assign rxc_rise = rx_clk_i & ~rxc_q;
  assign mii_dce = dce_mode_i & ~rmii_mode_i;
  assign gen_half = speed_100_i ? DIV_W'(`MRP_DCE_HALF_100) : DIV_W'(`MRP_DCE_HALF_10);

  // dce tx/rx clock made from reference edges
  mrp_clk_div #(.W(DIV_W)) u_gen_div (
    .clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .en_i(ref_rise & mii_dce),
    .half_i(gen_half),
    .clk_o(gen_clk),
    .rise_o(gen_rise)
  );

  // rmii 10 Mbps decimation of reference edges
  mrp_clk_div #(.W(DIV_W)) u_dec_div (
    .clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .en_i(ref_rise & rmii_mode_i),
    .half_i(DIV_W'(`MRP_RMII_DEC_HALF)),
    .clk_o(),
    .rise_o(dec_rise)
  );

  // reference output; its accuracy is only that of the system clock
  mrp_clk_div #(.W(DIV_W)) u_refo_div (
    .clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .en_i(1'b1),
    .half_i(DIV_W'(`MRP_REFO_HALF)),
    .clk_o(divided_ref_clock_out_o),
    .rise_o(refo_rise)
  );

  assign tx_clk_o = gen_clk;
  assign rx_clk_o = gen_clk;

  always_comb
  begin
    if (rmii_mode_i)
    begin
      tx_tick = speed_100_i ? ref_rise : dec_rise;
      rx_tick = speed_100_i ? ref_rise : dec_rise;
    end
    else
    begin
      tx_tick = dce_mode_i ? gen_rise : txc_rise;
      rx_tick = dce_mode_i ? gen_rise : rxc_rise;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_clk_oe_o <= 1'b0;
      rx_clk_oe_o <= 1'b0;
    end
    else
    begin
      tx_clk_oe_o <= mii_dce;
      rx_clk_oe_o <= mii_dce;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit
  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_sh = tx_sh;
    next_tx_cnt = tx_cnt;
    next_tx_last_q = tx_last_q;
    next_tx_en = tx_en_o;
    next_txd = txd_o;
    next_tx_ready = 1'b0;
    next_tx_col = 1'b0;
    if (tx_tick)
    begin
      case (tx_state)
        mrp_pkg::TX_IDLE:
        begin
          next_tx_en = 1'b0;
          if (tx_valid_i)
          begin
            next_tx_ready = 1'b1;
            next_tx_last_q = tx_last_i;
            next_txd = first_unit(tx_byte_i, rmii_mode_i);
            next_tx_sh = drop_unit(tx_byte_i, rmii_mode_i);
            next_tx_cnt = rmii_mode_i ? `MRP_RMII_UNITS_LAST : `MRP_MII_UNITS_LAST;
            next_tx_en = 1'b1;
            next_tx_state = mrp_pkg::TX_SEND;
          end
        end
        mrp_pkg::TX_SEND:
        begin
          if (collision_detect_in_i && !full_duplex_i)
          begin
            next_tx_col = 1'b1;
            next_tx_en = 1'b0;
            next_tx_state = mrp_pkg::TX_GAP;
          end
          else if (tx_cnt != 2'h0)
          begin
            next_txd = first_unit(tx_sh, rmii_mode_i);
            next_tx_sh = drop_unit(tx_sh, rmii_mode_i);
            next_tx_cnt = tx_cnt - 2'h1;
          end
          else if (!tx_last_q && tx_valid_i)
          begin
            next_tx_ready = 1'b1;
            next_tx_last_q = tx_last_i;
            next_txd = first_unit(tx_byte_i, rmii_mode_i);
            next_tx_sh = drop_unit(tx_byte_i, rmii_mode_i);
            next_tx_cnt = rmii_mode_i ? `MRP_RMII_UNITS_LAST : `MRP_MII_UNITS_LAST;
          end
          else
          begin
            // an underrun ends the frame as well
            next_tx_en = 1'b0;
            next_tx_state = mrp_pkg::TX_GAP;
          end
        end
        mrp_pkg::TX_GAP:
        begin
          next_tx_state = mrp_pkg::TX_IDLE;
        end
        default:
        begin
          next_tx_en = 1'b0;
          next_tx_state = mrp_pkg::TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_state <= mrp_pkg::TX_IDLE;
      tx_sh <= 8'h00;
      tx_cnt <= 2'h0;
      tx_last_q <= 1'b0;
      tx_en_o <= 1'b0;
      txd_o <= 4'h0;
      tx_ready_o <= 1'b0;
      tx_col_o <= 1'b0;
    end
    else
    begin
      tx_state <= next_tx_state;
      tx_sh <= next_tx_sh;
      tx_cnt <= next_tx_cnt;
      tx_last_q <= next_tx_last_q;
      tx_en_o <= next_tx_en;
      txd_o <= next_txd;
      tx_ready_o <= next_tx_ready;
      tx_col_o <= next_tx_col;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive
  assign rx_line_valid = rmii_mode_i ? receive_carrier_sense_i : rx_dv_i;

  always_comb
  begin
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_rx_in_frame = rx_in_frame;
    next_rx_err_acc = rx_err_acc;
    next_rx_byte = rx_byte_o;
    next_rx_valid = 1'b0;
    next_rx_end = 1'b0;
    next_rx_err = rx_err_o;
    if (rx_tick)
    begin
      if (rx_line_valid)
      begin
        next_rx_in_frame = 1'b1;
        next_rx_err_acc = rx_err_acc | rx_err_i;
        next_rx_sh = rmii_mode_i ? {rxd_i[1:0], rx_sh[7:2]} : {rxd_i, rx_sh[7:4]};
        if (rx_cnt == (rmii_mode_i ? `MRP_RMII_UNITS_LAST : `MRP_MII_UNITS_LAST))
        begin
          next_rx_cnt = 2'h0;
          next_rx_byte = next_rx_sh;
          next_rx_valid = 1'b1;
        end
        else
        begin
          next_rx_cnt = rx_cnt + 2'h1;
        end
      end
      else if (rx_in_frame)
      begin
        // data is discarded here; a trailing part byte flags an error
        next_rx_end = 1'b1;
        next_rx_err = rx_err_acc | (rx_cnt != 2'h0);
        next_rx_in_frame = 1'b0;
        next_rx_err_acc = 1'b0;
        next_rx_cnt = 2'h0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rx_sh <= 8'h00;
      rx_cnt <= 2'h0;
      rx_in_frame <= 1'b0;
      rx_err_acc <= 1'b0;
      rx_byte_o <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_end_o <= 1'b0;
      rx_err_o <= 1'b0;
    end
    else
    begin
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      rx_in_frame <= next_rx_in_frame;
      rx_err_acc <= next_rx_err_acc;
      rx_byte_o <= next_rx_byte;
      rx_valid_o <= next_rx_valid;
      rx_end_o <= next_rx_end;
      rx_err_o <= next_rx_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // assertion helper: reference edges since the last decimated tick; it starts at
  // the divider's half count because the first decimated tick comes after half a period
  logic [4:0] ref_gap;
  logic [4:0] next_ref_gap;

  always_comb
  begin
    next_ref_gap = ref_gap;
    if (dec_rise)
    begin
      next_ref_gap = {4'h0, ref_rise & rmii_mode_i};
    end
    else if (ref_rise && rmii_mode_i && ref_gap != 5'h1F)
    begin
      next_ref_gap = ref_gap + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref_gap <= 5'(`MRP_RMII_DEC_HALF);
    end
    else
    begin
      ref_gap <= next_ref_gap;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_tx_en_tick: assert property ($changed(tx_en_o) |-> $past(tx_tick))
    else $error("tx enable moved off a transmit edge");
  a_txd_held: assert property (!$past(tx_tick) |-> $stable(txd_o))
    else $error("transmit data changed between edges");
  a_rmii_dibit: assert property (rmii_mode_i && $past(rmii_mode_i) && tx_en_o |-> txd_o[3:2] == 2'h0)
    else $error("rmii drove upper data bits");
  a_enable_gap: assert property ($fell(tx_en_o) |=> !tx_en_o)
    else $error("tx enable gap too short");
  a_ready_take: assert property (tx_ready_o |-> $past(tx_tick && tx_valid_i))
    else $error("byte taken without a valid request");
  a_rx_discard: assert property (rx_valid_o |-> $past(rx_tick && rx_line_valid))
    else $error("byte delivered without data valid");
  a_clk_dir: assert property (tx_clk_oe_o |-> $past(dce_mode_i && !rmii_mode_i))
    else $error("clock pin driven outside mii dce");
  a_col_half: assert property (tx_col_o |-> !$past(full_duplex_i) && !tx_en_o)
    else $error("collision honoured in full duplex");
  a_rmii_slow: assert property (rmii_mode_i && !speed_100_i && rx_tick |->
    ref_gap == 5'(`MRP_RMII_DEC_PERIODS))
    else $error("rmii 10 sampled off the decimated edge");

  c_tx_frame: cover property ($rose(tx_en_o) ##[1:200] $fell(tx_en_o));
  c_rx_byte: cover property (rx_valid_o ##[1:200] rx_end_o);
  c_collision: cover property (tx_col_o);
  c_refo: cover property (refo_rise);
endmodule

// file: inc/mrp_regs.svh
// timing counts and field constants of the mii/rmii port
`ifndef MRP_REGS_SVH
`define MRP_REGS_SVH
`define MRP_SYS_CLK_KHZ 10000
`define MRP_REF_CLK_MAX_KHZ 50000
`define MRP_MII_FAST_KHZ 25000
`define MRP_MII_SLOW_KHZ 2500
`define MRP_DCE_HALF_100 (`MRP_REF_CLK_MAX_KHZ / `MRP_MII_FAST_KHZ / 2)
`define MRP_DCE_HALF_10 (`MRP_REF_CLK_MAX_KHZ / `MRP_MII_SLOW_KHZ / 2)
`define MRP_RMII_DEC_PERIODS 10
`define MRP_RMII_DEC_HALF (`MRP_RMII_DEC_PERIODS / 2)
`define MRP_REFO_HALF 1
`define MRP_MII_UNITS_LAST 2'h1
`define MRP_RMII_UNITS_LAST 2'h3
`define MRP_MII_SHIFT 4
`define MRP_RMII_SHIFT 2
`endif

// file: inc/mrp_pkg.sv
// types of the mii/rmii port
package mrp_pkg;
  typedef enum logic [2:0]
  {
    TX_IDLE = 3'h1,
    TX_SEND = 3'h2,
    TX_GAP = 3'h4
  } mrp_tx_state_e;
endpackage

// file: hdl/mrp_clk_div.sv
// counting clock divider with a registered rising-edge pulse
`timescale 1ns/1ps
module mrp_clk_div #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic [W-1:0] half_i,
  output logic clk_o,
  output logic rise_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_clk;
  logic next_rise;

  // half_i counts enable pulses per half period; zero behaves as one
  always_comb
  begin
    next_cnt = cnt;
    next_clk = clk_o;
    next_rise = 1'b0;
    if (en_i)
    begin
      if (W'(cnt + W'(1)) >= half_i)
      begin
        next_cnt = {W{1'b0}};
        next_clk = ~clk_o;
        next_rise = ~clk_o;
      end
      else
      begin
        next_cnt = W'(cnt + W'(1));
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt <= {W{1'b0}};
      clk_o <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      clk_o <= next_clk;
      rise_o <= next_rise;
    end
  end
endmodule

// file: bench/mrp_phy_model.sv
// behavioural phy at the far side of the mii/rmii port
`timescale 1ns/1ps
module mrp_phy_model (
  input wire logic rmii_i,
  input wire logic dce_i,
  input wire logic hold10_i,
  input wire logic pin_clk_i,
  output logic ref_clk_o,
  output logic own_clk_o,
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  output logic [3:0] rxd_o,
  output logic rx_dv_o,
  output logic crs_dv_o,
  output logic rx_err_o,
  output logic [7:0] cap_byte_o,
  output int cap_cnt_o,
  output int frame_cnt_o
);
  logic clk = 1'b0;
  logic was_en = 1'b0;
  int units = 0;
  int sub = 0;
  // slow clock: the port samples clock pins, so they must stay well below sys_clk/2
  wire phy_clk = rmii_i ? clk : pin_clk_i;
  always #400 clk = ~clk;
  assign own_clk_o = clk;
  assign ref_clk_o = (rmii_i | dce_i) & clk;
  initial
  begin
    {rxd_o, rx_dv_o, crs_dv_o, rx_err_o} = 7'h00;
    cap_byte_o = 8'h00;
    cap_cnt_o = 0;
    frame_cnt_o = 0;
  end
  always @(posedge phy_clk)
  begin
    if (tx_en_i)
    begin
      // at 10 Mbps each dibit stands ten periods; the first sight of it is taken
      if (sub == 0)
      begin
        cap_byte_o = rmii_i ? {txd_i[1:0], cap_byte_o[7:2]} : {txd_i, cap_byte_o[7:4]};
        units = units + 1;
        if (units == (rmii_i ? 4 : 2))
        begin
          units = 0;
          cap_cnt_o = cap_cnt_o + 1;
        end
      end
      sub = hold10_i ? (sub + 1) % 10 : 0;
    end
    else
    begin
      units = 0;
      sub = 0;
      if (was_en)
        frame_cnt_o = frame_cnt_o + 1;
    end
    was_en = tx_en_i;
  end
  task automatic unit(input logic [3:0] d, input logic err);
    repeat (hold10_i ? 10 : 1)
    begin
      @(negedge phy_clk);
      rxd_o = d;
      rx_err_o = err;
      rx_dv_o = rmii_i ? 1'($urandom) : 1'b1;
      crs_dv_o = rmii_i ? 1'b1 : 1'($urandom);
    end
  endtask
  task automatic idle(input int n);
    int j;
    for (j = (hold10_i ? 10 * n : n); j > 0; j--)
    begin
      @(negedge phy_clk);
      rxd_o = ~rxd_o;
      rx_err_o = 1'($urandom);
      // the last idle unit leaves both valid lines low, so a mode switch sees no carrier
      rx_dv_o = rmii_i & (j > 1) & 1'($urandom);
      crs_dv_o = !rmii_i & (j > 1) & 1'($urandom);
    end
  endtask
endmodule

// file: bench/mrp_port_tb_top.sv
// self-checking bench of the mii/rmii port
`include "mrp_regs.svh"
`timescale 1ns/1ps
module mrp_port_tb_top;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic rmii = 1'b0;
  logic dce = 1'b0;
  logic spd = 1'b1;
  logic fdx = 1'b1;
  logic col = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_last = 1'b0;
  logic col_test = 1'b0;
  logic p;
  logic [2:0] cfg [5] = '{3'h1, 3'h3, 3'h2, 3'h5, 3'h4};
  logic [7:0] exp_tx [$];
  logic [7:0] exp_rx [$];
  logic exp_end [$];
  int n_fail = 0;
  int cmp_count = 0;
  int ref_n = 0;
  int cap_cnt;
  int frame_cnt;
  int m;
  int i;
  int n;
  wire ref_clk, own_clk, tx_clk_o, tx_clk_oe_o, rx_clk_o, rx_clk_oe_o, refo;
  wire tx_en, tx_ready, tx_col, rx_valid, rx_end, rx_err, rx_dv, crs_dv, rx_err_in;
  wire [3:0] txd;
  wire [3:0] rxd;
  wire [7:0] rx_byte;
  wire [7:0] cap_byte;
  wire tx_pin = tx_clk_oe_o ? tx_clk_o : own_clk;
  wire rx_pin = rx_clk_oe_o ? rx_clk_o : own_clk;
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge ref_clk) ref_n++;
  mrp_port mrp_port_inst (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .rmii_mode_i(rmii), .dce_mode_i(dce),
    .speed_100_i(spd), .full_duplex_i(fdx), .ref_clk_i(ref_clk), .tx_clk_i(tx_pin),
    .tx_clk_o(tx_clk_o), .tx_clk_oe_o(tx_clk_oe_o), .rx_clk_i(rx_pin), .rx_clk_o(rx_clk_o),
    .rx_clk_oe_o(rx_clk_oe_o), .divided_ref_clock_out_o(refo), .tx_en_o(tx_en), .txd_o(txd),
    .rxd_i(rxd), .rx_dv_i(rx_dv), .receive_carrier_sense_i(crs_dv), .rx_err_i(rx_err_in),
    .collision_detect_in_i(col), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid),
    .tx_last_i(tx_last), .tx_ready_o(tx_ready), .tx_col_o(tx_col), .rx_byte_o(rx_byte),
    .rx_valid_o(rx_valid), .rx_end_o(rx_end), .rx_err_o(rx_err)
  );
  mrp_phy_model mrp_phy_model_inst (
    .rmii_i(rmii), .dce_i(dce), .hold10_i(rmii & !spd), .pin_clk_i(tx_pin),
    .ref_clk_o(ref_clk), .own_clk_o(own_clk), .tx_en_i(tx_en), .txd_i(txd), .rxd_o(rxd),
    .rx_dv_o(rx_dv), .crs_dv_o(crs_dv), .rx_err_o(rx_err_in), .cap_byte_o(cap_byte),
    .cap_cnt_o(cap_cnt), .frame_cnt_o(frame_cnt)
  );
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one idle edge first so valid never toggles twice in one time step
  task automatic send_frame(input int nb, input int col_at);
    int k;
    int w;
    logic hit;
    hit = 1'b0;
    @(posedge sys_clk_i);
    #1;
    for (k = 0; k < nb && !hit; k++)
    begin
      tx_byte = 8'($urandom);
      tx_valid = 1'b1;
      tx_last = k == nb - 1;
      w = 0;
      do
      begin
        @(posedge sys_clk_i);
        #1;
        w++;
      end while (tx_ready !== 1'b1 && tx_col !== 1'b1 && w < 1000);
      hit = tx_col === 1'b1;
      chk(tx_en, !hit);
      if (col_at >= nb)
        exp_tx.push_back(tx_byte);
      col = col | k == col_at;
    end
    tx_valid = 1'b0;
    tx_last = 1'b0;
    chk(hit, col_at < nb);
  endtask
  task automatic rx_frame(input int nb, input logic err, input logic part);
    logic [7:0] b;
    logic [7:0] d;
    int k;
    int u;
    for (k = 0; k < nb; k++)
    begin
      b = 8'($urandom);
      exp_rx.push_back(b);
      for (u = 0; u < (rmii ? 4 : 2); u++)
      begin
        d = rmii ? (b >> 2 * u) & 8'h03 : (b >> 4 * u) & 8'h0F;
        mrp_phy_model_inst.unit(d[3:0], err && u == 1);
      end
    end
    if (part)
      mrp_phy_model_inst.unit(4'h1, 1'b0);
    exp_end.push_back(err | part);
    mrp_phy_model_inst.idle(4);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i)
  begin
    #1;
    if (rx_valid === 1'b1)
      chk(rx_byte, exp_rx.size() > 0 ? exp_rx.pop_front() : 9'h1FF);
    if (rx_end === 1'b1)
      chk(rx_err, exp_end.size() > 0 ? exp_end.pop_front() : 2'h2);
  end
  always @(cap_cnt)
  begin
    // let the captured byte settle before it is read
    #1;
    if (!col_test)
      chk(cap_byte, exp_tx.size() > 0 ? exp_tx.pop_front() : 9'h1FF);
  end
  initial
  begin
    #(40000 * 100);
    n_fail++;
    final_report();
  end
  initial
  begin
    void'($urandom(40));
    for (m = 0; m < 5; m++)
    begin
      // mode pins change just after an edge, as the transmit request and collision inputs do
      @(posedge sys_clk_i);
      #1;
      {rmii, dce, spd} = cfg[m];
      fdx = m != 0;
      // in full duplex a stuck collision line must not disturb frames
      col = rmii;
      rstn_i = 1'b0;
      repeat (8) @(posedge sys_clk_i);
      #1;
      rstn_i = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk(tx_clk_oe_o, dce & !rmii);
      chk(rx_clk_oe_o, dce & !rmii);
      n = 0;
      for (i = 0; i < 20; i++)
      begin
        p = refo;
        @(posedge sys_clk_i);
        #1;
        n = n + (refo !== p);
      end
      chk(n, 20 / `MRP_REFO_HALF);
      if (dce && !rmii)
      begin
        @(posedge tx_clk_o);
        n = ref_n;
        @(posedge tx_clk_o);
        chk(ref_n - n, 2 * (spd ? `MRP_DCE_HALF_100 : `MRP_DCE_HALF_10));
        // the receive clock pin is made by the same divider
        @(posedge rx_clk_o);
        n = ref_n;
        @(posedge rx_clk_o);
        chk(ref_n - n, 2 * (spd ? `MRP_DCE_HALF_100 : `MRP_DCE_HALF_10));
      end
      // rmii 10 sends as well: one dibit per ten reference periods
      n = frame_cnt;
      send_frame(3, 9);
      send_frame(3, 9);
      i = 0;
      while ((tx_en !== 1'b0 || frame_cnt - n < 2) && i < 3000)
      begin
        @(posedge sys_clk_i);
        #1;
        i++;
      end
      chk(frame_cnt - n, 2);
      if (m == 0)
      begin
        col_test = 1'b1;
        send_frame(4, 1);
        col = 1'b0;
        repeat (20) @(posedge sys_clk_i);
        col_test = 1'b0;
      end
      rx_frame(3, 1'b0, 1'b0);
      rx_frame(1, 1'b1, 1'b0);
      rx_frame(2, 1'b0, 1'b1);
      chk(exp_rx.size() + exp_end.size() + exp_tx.size(), 0);
    end
    final_report();
  end
endmodule
